// ===== design/sec_err_log_pkg.sv
/*
 secondary error header log: register offsets, field positions, reset values.
 assumes a 32-bit apb register bus with byte addresses.
*/
package sec_err_log_pkg;
   localparam logic [11:0] cap_ctrl_off      = 12'h138;
   localparam logic [11:0] hdr_attr_low_off  = 12'h13c;
   localparam logic [11:0] hdr_cmd_attr_off  = 12'h140;
   localparam logic [11:0] hdr_addr_low_off  = 12'h144;
   localparam logic [11:0] hdr_addr_high_off = 12'h148;
   localparam logic [11:0] err_status_off    = 12'h150;
   localparam logic [11:0] err_mask_off      = 12'h154;
   localparam logic [11:0] log_clear_off     = 12'h158;
   localparam int          ptr_w             = 5;
   localparam int          attr_hi_lsb       = 0;
   localparam int          cmd_low_lsb       = 4;
   localparam int          cmd_up_lsb        = 8;
   localparam logic [31:0] log_reset_val     = 32'h0000_0000;
   localparam logic [1:0]  irq_mask_reset    = 2'h0;
endpackage

// ===== design/secondary_error_header_log.sv
/*
 sticky first-error pointer and header log registers for the secondary bus,
 read over apb. assumes the capture inputs come from logic on clock, already
 sampled; sticky_rst is the power-on reset, rst the ordinary reset.
*/
// Function
// (RL1) a five-bit read-only first-error pointer sits in bits 4:0 of the capability register, zero at reset.
// (RL2) the low 32 bits of the 36-bit attribute value are captured into the first header log.
// (RL3) attribute bits 35:32 sit in bits 3:0 of the second header log.
// (RL4) the second-address-phase command of a dual-cycle transaction sits in bits 11:8 of the second log.
// (RL5) the first-address-phase command sits in bits 7:4 of the second log.
// (RL6) the first-address-phase address fills the third header log.
// (RL7) the logged address is one 64-bit value, low half from phase one, high half from phase two.
// (RL8) all header logs reset to zero, are sticky and cannot be written by software.
// (RL9) a single-address-cycle transaction logs zero as the upper address.
// (RL10) the logs change only on the first error and hold until software clears the status.
module secondary_error_header_log
   import sec_err_log_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              sticky_rst,
   input  wire logic              err_valid,
   input  wire logic [ptr_w-1:0]  err_ptr,
   input  wire logic [35:0]       txn_attribute,
   input  wire logic [3:0]        cmd_phase1,
   input  wire logic [3:0]        cmd_phase2,
   input  wire logic [31:0]       addr_phase1,
   input  wire logic [31:0]       addr_phase2,
   input  wire logic              dual_cycle,
   input  wire logic              status_clear,
   output logic                   log_held,
   output logic                   irq,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr
);
   logic [ptr_w-1:0] first_error_pointer_q;
   logic [35:0]      txn_attribute_log_q;
   logic [3:0]       upper_command_log_q;
   logic [3:0]       lower_command_log_q;
   logic [63:0]      addr_log_q;
   logic             held_q;
   logic [1:0]       status_q;
   logic [1:0]       mask_q;
   logic [31:0]      rdata_q;

   wire acc      = psel & penable;
   wire wr_acc   = acc & pwrite;
   wire rd_acc   = acc & ~pwrite;
   // read word latched in setup so it already stands at the access edge
   wire rd_setup = psel & ~penable & ~pwrite;
   wire sel_cap  = paddr == cap_ctrl_off;
   wire sel_hl1  = paddr == hdr_attr_low_off;
   wire sel_hl2  = paddr == hdr_cmd_attr_off;
   wire sel_hl3  = paddr == hdr_addr_low_off;
   wire sel_hl4  = paddr == hdr_addr_high_off;
   wire sel_sts  = paddr == err_status_off;
   wire sel_msk  = paddr == err_mask_off;
   wire sel_clr  = paddr == log_clear_off;
   wire mapped   = sel_cap | sel_hl1 | sel_hl2 | sel_hl3 | sel_hl4 | sel_sts | sel_msk | sel_clr;
   // software clears the held log by status clear port or by writing 1 to bit 0
   wire sw_clr   = status_clear | (wr_acc & sel_clr & pwdata[0]);
   wire capture  = err_valid & ~held_q; // [RL10]
   wire sts_rd   = rd_acc & sel_sts;
   // event 0: a log captured, event 1: an error dropped while the log was held
   wire [1:0] evt = {err_valid & held_q, capture};
   wire [63:0] addr_full = {dual_cycle ? addr_phase2 : 32'h0000_0000, addr_phase1}; // [RL7] [RL9]

   wire [31:0] cap_word = {{(32-ptr_w){1'b0}}, first_error_pointer_q}; // [RL1]
   wire [31:0] hl2_word = {20'h00000, upper_command_log_q, lower_command_log_q,
                           txn_attribute_log_q[35:32]}; // [RL3] [RL4] [RL5]
   wire [31:0] rd_mux   = sel_cap ? cap_word :
                          sel_hl1 ? txn_attribute_log_q[31:0] :
                          sel_hl2 ? hl2_word :
                          sel_hl3 ? addr_log_q[31:0] :
                          sel_hl4 ? addr_log_q[63:32] :
                          sel_sts ? {30'h0, status_q} :
                          sel_msk ? {30'h0, mask_q} : 32'h0000_0000;

   // sticky logs live on the power-on reset so an ordinary reset keeps them
   always_ff @(posedge clock or posedge sticky_rst) begin
      if (sticky_rst) begin
         first_error_pointer_q <= '0;                        // [RL1] [RL8]
         txn_attribute_log_q   <= {4'h0, log_reset_val};
         upper_command_log_q   <= 4'h0;
         lower_command_log_q   <= 4'h0;
         addr_log_q            <= {log_reset_val, log_reset_val};
      end else if (capture) begin
         first_error_pointer_q <= err_ptr;                   // [RL1]
         txn_attribute_log_q   <= txn_attribute;             // [RL2] [RL3]
         upper_command_log_q   <= dual_cycle ? cmd_phase2 : 4'h0; // [RL4]
         lower_command_log_q   <= cmd_phase1;                // [RL5]
         addr_log_q            <= addr_full;                 // [RL6] [RL7]
      end
   end

   // an error in the cycle that clears a held log is dropped: set wins over clear only when not held
   always_ff @(posedge clock or posedge sticky_rst) begin
      if (sticky_rst)
         held_q <= 1'b0;
      else if (capture)
         held_q <= 1'b1;                                     // [RL10]
      else if (sw_clr)
         held_q <= 1'b0;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_q <= 2'h0;
         mask_q   <= irq_mask_reset;
         rdata_q  <= 32'h0000_0000;
      end else begin
         // only bits already shown to software clear, so a late event survives
         status_q <= evt | (status_q & ~(sts_rd ? rdata_q[1:0] : 2'h0));
         if (wr_acc & sel_msk)
            mask_q <= pwdata[1:0];
         if (rd_setup)
            rdata_q <= rd_mux;
      end
   end

   assign prdata   = rdata_q;
   assign pready   = 1'b1;
   assign pslverr  = acc & ~mapped;
   assign log_held = held_q;
   assign irq      = |(status_q & mask_q);

   sequence err_taken_s;
      err_valid && !held_q;
   endsequence

   sequence log_frozen_s;
      held_q && !sw_clr;
   endsequence

   sequence rd_setup_s;
      psel && !penable && !pwrite;
   endsequence

   sequence err_dropped_s;
      err_valid && held_q;
   endsequence

   ptr_capture_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL1]
      err_taken_s |=> first_error_pointer_q == $past(err_ptr))
      else $error("pointer not captured");
   attr_capture_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL2]
      err_taken_s |=> txn_attribute_log_q[31:0] == $past(txn_attribute[31:0]))
      else $error("attribute low not captured");
   attr_high_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL3]
      err_taken_s |=> hl2_word[3:0] == $past(txn_attribute[35:32]))
      else $error("attribute high misplaced");
   cmd_upper_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL4]
      err_taken_s ##0 dual_cycle |=> hl2_word[11:8] == $past(cmd_phase2))
      else $error("upper command misplaced");
   cmd_lower_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL5]
      err_taken_s |=> hl2_word[7:4] == $past(cmd_phase1))
      else $error("lower command misplaced");
   addr_low_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL6]
      err_taken_s |=> addr_log_q[31:0] == $past(addr_phase1))
      else $error("address low not captured");
   addr_dac_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL7]
      err_taken_s ##0 dual_cycle |=> addr_log_q[63:32] == $past(addr_phase2))
      else $error("address high not captured");
   no_sw_write_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL8]
      wr_acc && !capture |=> $stable(addr_log_q) && $stable(txn_attribute_log_q))
      else $error("log changed by software write");
   sac_zero_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL9]
      err_taken_s ##0 !dual_cycle |=> addr_log_q[63:32] == 32'h0000_0000)
      else $error("upper address not zero");
   log_hold_a: assert property (@(posedge clock) disable iff (sticky_rst) // [RL10]
      log_frozen_s |=> $stable(first_error_pointer_q) && $stable(addr_log_q) && held_q)
      else $error("held log changed");

   rd_cap_a: assert property ( // [RL1]
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 sel_cap |=> prdata == {{(32-ptr_w){1'b0}}, $past(first_error_pointer_q)})
      else $error("pointer read wrong");

   rd_attr_low_a: assert property ( // [RL2]
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 sel_hl1 |=> prdata == $past(txn_attribute_log_q[31:0]))
      else $error("attribute low read wrong");

   rd_cmd_attr_a: assert property ( // [RL3] [RL4] [RL5]
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 sel_hl2 |=> prdata == {20'h00000, $past(upper_command_log_q),
         $past(lower_command_log_q), $past(txn_attribute_log_q[35:32])})
      else $error("command log read wrong");

   rd_addr_low_a: assert property ( // [RL6]
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 sel_hl3 |=> prdata == $past(addr_log_q[31:0]))
      else $error("address low read wrong");

   rd_addr_high_a: assert property ( // [RL7]
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 sel_hl4 |=> prdata == $past(addr_log_q[63:32]))
      else $error("address high read wrong");

   rd_status_a: assert property (
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 sel_sts |=> prdata == {30'h0, $past(status_q)})
      else $error("status read wrong");

   rd_mask_a: assert property (
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 sel_msk |=> prdata == {30'h0, $past(mask_q)})
      else $error("mask read wrong");

   rd_unmapped_a: assert property (
      @(posedge clock) disable iff (rst)
      rd_setup_s ##0 !mapped |=> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   rdata_hold_a: assert property (
      @(posedge clock) disable iff (rst)
      !rd_setup |=> $stable(prdata))
      else $error("read data moved between reads");

   slverr_set_a: assert property (
      @(posedge clock) disable iff (rst)
      acc && !mapped |-> pslverr)
      else $error("unmapped access not flagged");

   slverr_clear_a: assert property (
      @(posedge clock) disable iff (rst)
      acc && mapped |-> !pslverr)
      else $error("mapped access flagged");

   ready_high_a: assert property (
      @(posedge clock) disable iff (rst)
      acc |-> pready)
      else $error("access stalled");

   attr_full_a: assert property ( // [RL2] [RL3]
      @(posedge clock) disable iff (sticky_rst)
      err_taken_s |=> txn_attribute_log_q == $past(txn_attribute))
      else $error("attribute not captured whole");

   cmd_up_zero_a: assert property ( // [RL4]
      @(posedge clock) disable iff (sticky_rst)
      err_taken_s ##0 !dual_cycle |=> upper_command_log_q == 4'h0)
      else $error("upper command not zero");

   log_idle_a: assert property ( // [RL8] [RL10]
      @(posedge clock) disable iff (sticky_rst)
      !capture |=> $stable(txn_attribute_log_q) && $stable(upper_command_log_q)
         && $stable(lower_command_log_q) && $stable(first_error_pointer_q))
      else $error("log changed without capture");

   drop_keep_a: assert property ( // [RL10]
      @(posedge clock) disable iff (sticky_rst)
      err_dropped_s |=> $stable(addr_log_q) && $stable(txn_attribute_log_q))
      else $error("later error overwrote log");

   held_set_a: assert property ( // [RL10]
      @(posedge clock) disable iff (sticky_rst)
      capture |=> held_q)
      else $error("log not held after capture");

   held_clear_a: assert property ( // [RL10]
      @(posedge clock) disable iff (sticky_rst)
      sw_clr && !capture |=> !held_q)
      else $error("log not released by clear");

   held_idle_a: assert property ( // [RL10]
      @(posedge clock) disable iff (sticky_rst)
      !capture && !sw_clr |=> $stable(held_q))
      else $error("held flag moved by itself");

   status_capture_a: assert property (
      @(posedge clock) disable iff (rst)
      capture |=> status_q[0])
      else $error("capture event lost");

   status_drop_a: assert property (
      @(posedge clock) disable iff (rst)
      err_dropped_s |=> status_q[1])
      else $error("dropped error event lost");

   status_clear_a: assert property (
      @(posedge clock) disable iff (rst)
      sts_rd && !err_valid |=> (status_q & $past(rdata_q[1:0])) == 2'h0)
      else $error("status not cleared by read");

   mask_write_a: assert property (
      @(posedge clock) disable iff (rst)
      wr_acc && sel_msk |=> mask_q == $past(pwdata[1:0]))
      else $error("mask write lost");

   irq_raise_a: assert property (
      @(posedge clock) disable iff (rst)
      (status_q & mask_q) != 2'h0 |-> irq)
      else $error("interrupt missing");

   irq_quiet_a: assert property (
      @(posedge clock) disable iff (rst)
      (status_q & mask_q) == 2'h0 |-> !irq)
      else $error("interrupt without cause");
endmodule

// ===== tb/sec_bus_agent.sv
/* secondary bus agent that raises logged errors for the header log block.
   assumes one clock shared with the log block; driven by task calls. */
module sec_bus_agent
   import sec_err_log_pkg::*;
(
   input  wire logic             clock,
   output logic                  err_valid,
   output logic [ptr_w-1:0]      err_ptr,
   output logic [35:0]           txn_attribute,
   output logic [3:0]            cmd_phase1,
   output logic [3:0]            cmd_phase2,
   output logic [31:0]           addr_phase1,
   output logic [31:0]           addr_phase2,
   output logic                  dual_cycle
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      err_valid = 1'b0;
      {err_ptr, txn_attribute, cmd_phase1, cmd_phase2, addr_phase1, addr_phase2, dual_cycle} = '0;
   end
   task automatic fire(input logic [113:0] v);
      {err_ptr, txn_attribute, cmd_phase1, cmd_phase2, addr_phase1, addr_phase2, dual_cycle} <= v;
      err_valid <= 1'b1;
      @(posedge clock);
      err_valid <= 1'b0;
      // lines go stale after the phase: inverted so a late sample cannot pass
      {err_ptr, txn_attribute, cmd_phase1, cmd_phase2, addr_phase1, addr_phase2, dual_cycle} <= ~v;
      // let the capture edge settle before the caller looks at the block
      @(posedge clock);
   endtask
endmodule

// ===== tb/secondary_error_header_log_tb.sv
/* self-checking bench for the secondary error header log, apb master tasks.
   assumes sec_bus_agent as the error source; prdata is taken at the pready edge. */
module secondary_error_header_log_tb
   import sec_err_log_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst = 1, sticky_rst = 1, status_clear = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_q;
   logic        pready, pslverr, err_q, log_held, irq, err_valid, dual_cycle;
   logic [4:0]  err_ptr;
   logic [35:0] txn_attribute;
   logic [3:0]  cmd_phase1, cmd_phase2;
   logic [31:0] addr_phase1, addr_phase2;
   int n_errors = 0, comparisons = 0;
   always #10 clock = ~clock;
   sec_bus_agent sec_bus_agent_inst (
      .clock         (clock),
      .err_valid     (err_valid),
      .err_ptr       (err_ptr),
      .txn_attribute (txn_attribute),
      .cmd_phase1    (cmd_phase1),
      .cmd_phase2    (cmd_phase2),
      .addr_phase1   (addr_phase1),
      .addr_phase2   (addr_phase2),
      .dual_cycle    (dual_cycle)
   );
   secondary_error_header_log secondary_error_header_log_inst (
      .clock         (clock),
      .rst           (rst),
      .sticky_rst    (sticky_rst),
      .err_valid     (err_valid),
      .err_ptr       (err_ptr),
      .txn_attribute (txn_attribute),
      .cmd_phase1    (cmd_phase1),
      .cmd_phase2    (cmd_phase2),
      .addr_phase1   (addr_phase1),
      .addr_phase2   (addr_phase2),
      .dual_cycle    (dual_cycle),
      .status_clear  (status_clear),
      .log_held      (log_held),
      .irq           (irq),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .paddr         (paddr),
      .pwdata        (pwdata),
      .prdata        (prdata),
      .pready        (pready),
      .pslverr       (pslverr)
   );
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      err_q = pslverr;
      rd_q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never re-raises psel in this time step
      @(posedge clock);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd_q);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      n_errors++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0; sticky_rst <= 1'b0;
      @(posedge clock);
      rdc(cap_ctrl_off, 32'h0);
      for (int i = 0; i < 4; i++) rdc(hdr_attr_low_off + 12'(4*i), log_reset_val);
      bus(1'b1, hdr_attr_low_off, 32'hffff_ffff);
      rdc(hdr_attr_low_off, log_reset_val);
      bus(1'b0, 12'h1fc, 32'h0);
      chk("slverr", 32'h1, {31'h0, err_q});
      sec_bus_agent_inst.fire({5'h13, 36'h9a5c31e7f, 4'h7, 4'hd, 32'h8000_1234, 32'h0000_00c5, 1'b1});
      chk("held", 32'h1, {31'h0, log_held});
      chk("irq", 32'h0, {31'h0, irq});
      rdc(cap_ctrl_off, 32'h0000_0013);
      rdc(hdr_attr_low_off, 32'ha5c3_1e7f);
      rdc(hdr_cmd_attr_off, 32'h0000_0d79);
      rdc(hdr_addr_low_off, 32'h8000_1234);
      rdc(hdr_addr_high_off, 32'h0000_00c5);
      sec_bus_agent_inst.fire({5'h02, 36'h1_1111_1111, 4'h3, 4'h4, 32'h0bad_0bad, 32'h1, 1'b1});
      rdc(hdr_attr_low_off, 32'ha5c3_1e7f);
      rdc(cap_ctrl_off, 32'h0000_0013);
      rdc(err_status_off, 32'h3);
      rdc(err_status_off, 32'h0);
      bus(1'b1, err_mask_off, 32'h1);
      status_clear <= 1'b1;
      @(posedge clock);
      status_clear <= 1'b0;
      sec_bus_agent_inst.fire({5'h1f, 36'h0_0000_0042, 4'h6, 4'hb, 32'hdead_beef, 32'h5555_aaaa, 1'b0});
      chk("irq", 32'h1, {31'h0, irq});
      rdc(hdr_cmd_attr_off, 32'h0000_0060);
      rdc(hdr_addr_high_off, 32'h0);
      rdc(err_status_off, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdc(hdr_addr_low_off, 32'hdead_beef);
      rdc(cap_ctrl_off, 32'h0000_001f);
      rdc(err_mask_off, 32'h0);
      wrap_up();
   end
endmodule
